//--- rtl/boot_strap_pin_capture.sv
// strap capture register bank with axi4-lite slave and host-port forwarding
//
// Operation
// - hardware boot always fetches rom at zero
// - low word captures serial0/serial1 strap pins
// - high word captures serial1/host/audio strap pins
// - only external reset pin recaptures straps
// - bits 31:8 reserved, software writes zeros
// - host boot copies three serial0 straps
`timescale 1ns/10ps
module boot_strap_pin_capture (
   input  wire logic                                  aclk,
   input  wire logic                                  aresetn,
   input  wire logic                                  ext_reset_n,
   input  wire logic [strap_pkg::strap_pin_count-1:0] strap_pins,
   output logic                                       fetch_start,
   output logic [31:0]                                fetch_addr,
   output logic                                       host_byte_address_bit,
   output logic                                       host_full_width_bit,
   output logic                                       host_nonmultiplexed_bit,
   input  wire logic [31:0]                           awaddr,
   input  wire logic                                  awvalid,
   output logic                                       awready,
   input  wire logic [31:0]                           wdata,
   input  wire logic [3:0]                            wstrb,
   input  wire logic                                  wvalid,
   output logic                                       wready,
   output logic [1:0]                                 bresp,
   output logic                                       bvalid,
   input  wire logic                                  bready,
   input  wire logic [31:0]                           araddr,
   input  wire logic                                  arvalid,
   output logic                                       arready,
   output logic [31:0]                                rdata,
   output logic [1:0]                                 rresp,
   output logic                                       rvalid,
   input  wire logic                                  rready
);
   import strap_pkg::*;

   // ----------------------------------------------------------------
   // boot fetch request
   // ----------------------------------------------------------------
   logic        started_reg;
   logic        started_next;
   logic        fetch_start_reg;
   logic        fetch_start_next;
   logic [31:0] fetch_addr_reg;

   always_comb begin
      started_next     = 1'b1;
      fetch_start_next = !started_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         started_reg     <= 1'b0;
         fetch_start_reg <= 1'b0;
         fetch_addr_reg  <= rom_boot_addr;
      end else begin
         started_reg     <= started_next;
         fetch_start_reg <= fetch_start_next;
         fetch_addr_reg  <= rom_boot_addr;
      end
   end

   assign fetch_start = fetch_start_reg;
   assign fetch_addr  = fetch_addr_reg;

   // ----------------------------------------------------------------
   // strap capture
   // ----------------------------------------------------------------
   // the capture flops are deliberately outside aresetn: emulator and
   // watchdog resets drive aresetn but must not disturb the straps.
   // while the pin is low the straps track, so the rising edge freezes them.
   logic                 ext_prev_reg;
   logic                 ext_prev_next;
   logic                 load;
   logic [cap_width-1:0] cap_low_reg;
   logic [cap_width-1:0] cap_low_next;
   logic [cap_width-1:0] cap_high_reg;
   logic [cap_width-1:0] cap_high_next;
   logic                 byte_addr_reg;
   logic                 byte_addr_next;
   logic                 full_width_reg;
   logic                 full_width_next;
   logic                 nonmux_reg;
   logic                 nonmux_next;
   logic                 host_boot;

   always_comb begin
      ext_prev_next   = ext_reset_n;
      load            = !ext_reset_n || !ext_prev_reg;
      host_boot       = strap_pins[host_chip_select_pin] == host_boot_select_level;
      cap_low_next    = cap_low_reg;
      cap_high_next   = cap_high_reg;
      byte_addr_next  = byte_addr_reg;
      full_width_next = full_width_reg;
      nonmux_next     = nonmux_reg;
      if (load) begin
         cap_low_next  = strap_pins[cap_width-1:0];
         cap_high_next = strap_pins[strap_pin_count-1:cap_width];
         if (host_boot) begin
            byte_addr_next  = strap_pins[serial0_input_pin];
            full_width_next = strap_pins[serial0_output_pin];
            nonmux_next     = strap_pins[serial0_clock_pin];
         end else begin
            byte_addr_next  = 1'b0;
            full_width_next = 1'b0;
            nonmux_next     = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      ext_prev_reg   <= ext_prev_next;
      cap_low_reg    <= cap_low_next;
      cap_high_reg   <= cap_high_next;
      byte_addr_reg  <= byte_addr_next;
      full_width_reg <= full_width_next;
      nonmux_reg     <= nonmux_next;
   end

   assign host_byte_address_bit   = byte_addr_reg;
   assign host_full_width_bit     = full_width_reg;
   assign host_nonmultiplexed_bit = nonmux_reg;

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   // both words are read-only, so writes are acknowledged and dropped;
   // wdata and wstrb are accepted but never stored.
   logic        aw_have_reg;
   logic        aw_have_next;
   logic [31:0] aw_addr_reg;
   logic [31:0] aw_addr_next;
   logic        w_have_reg;
   logic        w_have_next;
   logic        awready_reg;
   logic        awready_next;
   logic        wready_reg;
   logic        wready_next;
   logic        bvalid_reg;
   logic        bvalid_next;
   logic [1:0]  bresp_reg;
   logic [1:0]  bresp_next;
   logic        aw_take;
   logic        w_take;
   logic        aw_hit;

   always_comb begin
      aw_take      = awvalid && awready_reg;
      w_take       = wvalid && wready_reg;
      aw_have_next = aw_have_reg || aw_take;
      w_have_next  = w_have_reg || w_take;
      aw_addr_next = aw_take ? awaddr : aw_addr_reg;
      bvalid_next  = bvalid_reg && !bready;
      bresp_next   = bresp_reg;
      aw_hit       = aw_addr_next == strap_capture_low_addr
                  || aw_addr_next == strap_capture_high_addr;
      if (aw_have_next && w_have_next && !bvalid_next) begin
         bvalid_next  = 1'b1;
         bresp_next   = aw_hit ? resp_okay : resp_decerr;
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
      end
      awready_next = !aw_have_next && !bvalid_next;
      wready_next  = !w_have_next && !bvalid_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 32'h0000_0000;
         w_have_reg  <= 1'b0;
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= resp_okay;
      end else begin
         aw_have_reg <= aw_have_next;
         aw_addr_reg <= aw_addr_next;
         w_have_reg  <= w_have_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
      end
   end

   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   logic        arready_reg;
   logic        arready_next;
   logic        rvalid_reg;
   logic        rvalid_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0]  rresp_reg;
   logic [1:0]  rresp_next;
   logic        ar_take;

   always_comb begin
      ar_take     = arvalid && arready_reg;
      rvalid_next = rvalid_reg && !rready;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (ar_take) begin
         rvalid_next = 1'b1;
         rresp_next  = resp_okay;
         if (araddr == strap_capture_low_addr) begin
            rdata_next = {reserved_read_value, cap_low_reg};
         end else if (araddr == strap_capture_high_addr) begin
            rdata_next = {reserved_read_value, cap_high_reg};
         end else begin
            rdata_next = 32'h0000_0000;
            rresp_next = resp_decerr;
         end
      end
      arready_next = !rvalid_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= resp_okay;
      end else begin
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_ext_release;
      !ext_reset_n ##1 ext_reset_n;
   endsequence

   sequence s_ar_low;
      arvalid && arready && araddr == strap_capture_low_addr;
   endsequence

   sequence s_ar_high;
      arvalid && arready && araddr == strap_capture_high_addr;
   endsequence

   a_boot_fetch_pulse: assert property (@(posedge aclk)
      $rose(aresetn) |=> fetch_start && fetch_addr == rom_boot_addr ##1 !fetch_start)
      else $error("boot fetch pulse missing or wrong address");

   a_low_capture_edge: assert property (@(posedge aclk)
      s_ext_release |=> cap_low_reg == $past(strap_pins[7:0]))
      else $error("low capture word missed the reset release");

   a_high_capture_edge: assert property (@(posedge aclk)
      s_ext_release |=> cap_high_reg == $past(strap_pins[15:8]))
      else $error("high capture word missed the reset release");

   a_straps_hold_steady: assert property (@(posedge aclk)
      ext_reset_n && $past(ext_reset_n) |=>
         $stable(cap_low_reg) && $stable(cap_high_reg))
      else $error("capture changed without external reset");

   a_host_copy_bits: assert property (@(posedge aclk)
      s_ext_release ##0 !strap_pins[host_chip_select_pin] |=>
         host_byte_address_bit == $past(strap_pins[7])
         && host_full_width_bit == $past(strap_pins[6])
         && host_nonmultiplexed_bit == $past(strap_pins[5]))
      else $error("host config bits not copied from serial0 straps");

   a_read_low_word: assert property (@(posedge aclk) disable iff (!aresetn)
      s_ar_low |=> rvalid && rdata == {24'h00_0000, cap_low_reg})
      else $error("low word read data wrong");

   a_read_high_word: assert property (@(posedge aclk) disable iff (!aresetn)
      s_ar_high |=> rvalid && rdata == {24'h00_0000, cap_high_reg})
      else $error("high word read data wrong");

   a_write_acked_dropped: assert property (@(posedge aclk) disable iff (!aresetn)
      awvalid && awready && wvalid && wready && ext_reset_n && $past(ext_reset_n)
         |=> bvalid && $stable(cap_low_reg) && $stable(cap_high_reg))
      else $error("write not answered next cycle or changed a capture");

   a_rvalid_held: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped before rready");

endmodule : boot_strap_pin_capture

//--- rtl/strap_pkg.sv
// constants for the boot strap capture register bank
package strap_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [31:0] strap_capture_low_addr  = 32'h4000_0000;
   localparam logic [31:0] strap_capture_high_addr = 32'h4000_0004;
   localparam int          cap_width               = 8;
   localparam logic [23:0] reserved_read_value     = 24'h00_0000;
   // ----------------------------------------------------------------
   // hardware boot vector: internal rom, lowest address
   // ----------------------------------------------------------------
   localparam logic [31:0] rom_boot_addr = 32'h0000_0000;
   // ----------------------------------------------------------------
   // strap pin positions in the strap_pins vector (= capture bit)
   // ----------------------------------------------------------------
   localparam int strap_pin_count         = 16;
   localparam int serial1_clock_pin       = 0;
   localparam int serial1_output_pin      = 1;
   localparam int serial1_input_pin       = 2;
   localparam int serial0_enable_pin      = 3;
   localparam int serial0_select_pin      = 4;
   localparam int serial0_clock_pin       = 5;
   localparam int serial0_output_pin      = 6;
   localparam int serial0_input_pin       = 7;
   localparam int audio_serializer0_pin   = 8;
   localparam int receive_frame_sync0     = 9;
   localparam int transmit_frame_sync0    = 10;
   localparam int host_address0_pin       = 11;
   localparam int host_data0_pin          = 12;
   localparam int host_chip_select_pin    = 13;
   localparam int serial1_enable_pin      = 14;
   localparam int serial1_select_pin      = 15;
   localparam logic host_boot_select_level = 1'b0;
   // ----------------------------------------------------------------
   // axi4-lite response codes
   // ----------------------------------------------------------------
   localparam logic [1:0] resp_okay   = 2'b00;
   localparam logic [1:0] resp_decerr = 2'b11;
endpackage : strap_pkg

//--- test/strap_board_model.sv
// board strap resistor model that sets the boot-mode strap levels
`timescale 1ns/10ps
module strap_board_model (
   input  wire logic [2:0]                            boot_mode,
   input  wire logic [strap_pkg::strap_pin_count-1:0] spare_levels,
   output logic      [strap_pkg::strap_pin_count-1:0] strap_pins
);
   import strap_pkg::*;
   logic [3:0] code;
   // ----------------------------------------------------------------
   // code bits: host select, serial0 input, serial0 output, serial0 clock
   // ----------------------------------------------------------------
   always_comb begin
      case (boot_mode)
         3'h1:    code = 4'b1010;
         3'h2:    code = 4'b1001;
         3'h3:    code = 4'b1011;
         3'h4:    code = 4'b1101;
         3'h5:    code = 4'b1111;
         default: code = 4'b0000;
      endcase
      strap_pins = spare_levels;
      // host boot leaves the three serial0 straps free for the host-port options
      strap_pins[host_chip_select_pin] = code[3];
      if (code[3]) begin
         strap_pins[serial0_input_pin]  = code[2];
         strap_pins[serial0_output_pin] = code[1];
         strap_pins[serial0_clock_pin]  = code[0];
      end
   end
endmodule : strap_board_model

//--- test/tb.sv
// self-checking bench for the strap capture register bank
`timescale 1ns/10ps
module tb;
   import strap_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        ext_reset_n = 1'b0;
   logic [2:0]  boot_mode = 3'h0;
   logic [15:0] spare_levels = 16'h0000;
   logic [15:0] strap_pins, exp_pins;
   logic        fetch_start, host_byte_address_bit, host_full_width_bit, host_nonmultiplexed_bit;
   logic [31:0] fetch_addr, rdata;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb = 4'hf;
   int          fails = 0;
   int          comparisons = 0;

   always #12.5 aclk = ~aclk;

   strap_board_model i_board (.boot_mode(boot_mode), .spare_levels(spare_levels),
                              .strap_pins(strap_pins));
   boot_strap_pin_capture i_dut (.aclk(aclk), .aresetn(aresetn), .ext_reset_n(ext_reset_n),
      .strap_pins(strap_pins), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
      .host_byte_address_bit(host_byte_address_bit), .host_full_width_bit(host_full_width_bit),
      .host_nonmultiplexed_bit(host_nonmultiplexed_bit), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // ----------------------------------------------------------------
   // bus master; one idle edge after each access so no signal is set twice at once
   // ----------------------------------------------------------------
   task automatic axi_write(input logic [31:0] addr, input logic [31:0] data,
                            output logic [1:0] resp);
      int n;
      awaddr  <= addr;
      wdata   <= data;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      resp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
      if (n == 50) begin
         fails++;
         test_done();
      end
   endtask : axi_write

   task automatic axi_read(input logic [31:0] addr, input int hold, output logic [31:0] data,
                           output logic [1:0] resp);
      int n;
      araddr  <= addr;
      arvalid <= 1'b1;
      // a late rready keeps the read answer standing for a few cycles
      rready  <= (hold == 0);
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
         if (n + 1 >= hold) rready <= 1'b1;
      end
      data = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
      if (n == 50) begin
         fails++;
         test_done();
      end
   endtask : axi_read

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic bus_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check("boot pulse", {31'h0, fetch_start}, 32'h1);
      check("boot address", fetch_addr, rom_boot_addr);
      @(posedge aclk);
      check("boot pulse end", {31'h0, fetch_start}, 32'h0);
   endtask : bus_reset

   // pins move right after the release edge, so a late capture shows up
   task automatic capture_straps(input logic [2:0] mode, input logic [15:0] spare);
      boot_mode    <= mode;
      spare_levels <= spare;
      ext_reset_n  <= 1'b0;
      repeat (2) @(posedge aclk);
      ext_reset_n <= 1'b1;
      @(posedge aclk);
      exp_pins = strap_pins;
      spare_levels <= ~spare;
      boot_mode    <= mode ^ 3'h1;
      repeat (2) @(posedge aclk);
   endtask : capture_straps

   task automatic read_words(input string what);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(strap_capture_low_addr, 0, d, r);
      check({what, " low"}, d, {24'h0, exp_pins[7:0]});
      check("read resp", {30'h0, r}, {30'h0, resp_okay});
      axi_read(strap_capture_high_addr, 2, d, r);
      check({what, " high"}, d, {24'h0, exp_pins[15:8]});
   endtask : read_words

   task automatic test_mode(input logic [2:0] mode, input logic [15:0] spare);
      logic host;
      capture_straps(mode, spare);
      host = (exp_pins[host_chip_select_pin] == host_boot_select_level);
      read_words("mode");
      check("host bits", {29'h0, host_byte_address_bit, host_full_width_bit,
            host_nonmultiplexed_bit}, host ? {29'h0, exp_pins[7:5]} : 32'h0);
   endtask : test_mode

   task automatic test_writes_ignored();
      logic [31:0] d;
      logic [1:0]  r;
      axi_write(strap_capture_low_addr, {24'h0, ~exp_pins[7:0]}, r);
      check("write resp", {30'h0, r}, {30'h0, resp_okay});
      axi_write(strap_capture_high_addr, {24'h0, ~exp_pins[15:8]}, r);
      axi_write(32'h4000_0008, 32'h0, r);
      check("unmapped write resp", {30'h0, r}, {30'h0, resp_decerr});
      read_words("after write");
      axi_read(32'h4000_0008, 0, d, r);
      check("unmapped data", d, 32'h0);
      check("unmapped read resp", {30'h0, r}, {30'h0, resp_decerr});
   endtask : test_writes_ignored

   initial begin
      bus_reset();
      for (int m = 0; m < 6; m++) test_mode(3'(m), 16'h5a3c ^ 16'(m * 16'h1111));
      test_mode(3'h0, 16'ha5c3);
      // bus reset with new pin levels must keep the old capture
      spare_levels <= 16'hf00f;
      boot_mode    <= 3'h0;
      bus_reset();
      read_words("bus reset");
      test_writes_ignored();
      test_done();
   end
endmodule : tb
